/* hdl/trace_layout.sv */
// item-to-bit placement of one 576-bit packet
`timescale 1ns/10ps
module trace_layout
  import trace_pkg::*;
(
  input wire logic proto,
  input wire logic [ITEMS_PER_PKT*ITEM_W-1:0] items,
  output logic [PKT_BITS-1:0] pkt_vec
);

  logic [PKT_BITS-1:0] dflt_vec;
  logic [PKT_BITS-1:0] alt_vec;

  // ----------------------------------------
  // default layout: per group of four items, four low halves then four 2-bit tops
  // ----------------------------------------
  genvar g, k;
  generate
    for (g = 0; g < NUM_GROUPS; g++) begin : gen_grp
      for (k = 0; k < GROUP_ITEMS; k++) begin : gen_item
        localparam int IDX = g * GROUP_ITEMS + k;
        assign dflt_vec[g*GROUP_BITS + k*LOW_W +: LOW_W] = items[IDX*ITEM_W +: LOW_W];
        assign dflt_vec[g*GROUP_BITS + GROUP_HIGH_OFS + k*HIGH_W +: HIGH_W] =
          items[IDX*ITEM_W + LOW_W +: HIGH_W];
      end
    end
  endgenerate

  // alternate layout: items packed end to end
  assign alt_vec = items;

  assign pkt_vec = (proto == PROTO_ALT) ? alt_vec : dflt_vec;

endmodule

/* hdl/trace_packer.sv */
// trace item packer: 32 items of 18 bits into 18-word stream packets
`timescale 1ns/10ps
module trace_packer
  import trace_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic TRACE_PROTO,
  input wire logic ITEM_VALID,
  output logic ITEM_READY,
  input wire logic [ITEM_W-1:0] ITEM_DATA,
  input wire logic [SRC_W-1:0] ITEM_SRC,
  output logic M_AXIS_TVALID,
  input wire logic M_AXIS_TREADY,
  output logic [WORD_W-1:0] M_AXIS_TDATA,
  output logic M_AXIS_TLAST,
  output logic [SRC_W-1:0] M_AXIS_TID
);

  localparam int BUF_W = 1 + SRC_W + WORD_W;

  pack_state_e state_q, state_d;
  logic [ICNT_W-1:0] cnt_q, cnt_d;
  logic [WIDX_W-1:0] widx_q, widx_d;
  logic [SRC_W-1:0] tid_q, tid_d;
  logic proto_q, proto_d;
  logic ready_q, ready_d;
  logic take;
  logic push;
  logic buf_in_ready;
  logic [BUF_W-1:0] buf_in;
  logic [BUF_W-1:0] buf_out;
  logic [ITEM_W-1:0] item_q [ITEMS_PER_PKT];
  logic [ITEM_W-1:0] item_d [ITEMS_PER_PKT];
  logic [ITEMS_PER_PKT*ITEM_W-1:0] items_flat;
  logic [PKT_BITS-1:0] pkt_vec;
  logic [WORD_W-1:0] cur_word;

  // ----------------------------------------
  // item store
  // ----------------------------------------
  // slot cnt_q takes the offered item
  always_comb begin
    item_d = item_q;
    if (take) begin
      item_d[cnt_q] = ITEM_DATA;
    end
  end

  // cleared store keeps the placement checks free of unknowns
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      item_q <= '{default: '0};
    end else begin
      item_q <= item_d;
    end
  end

  genvar i;
  generate
    for (i = 0; i < ITEMS_PER_PKT; i++) begin : gen_flat
      assign items_flat[i*ITEM_W +: ITEM_W] = item_q[i];
    end
  endgenerate

  trace_layout u_layout (
    .proto(proto_q),
    .items(items_flat),
    .pkt_vec(pkt_vec)
  );

  assign cur_word = pkt_vec[widx_q*WORD_W +: WORD_W];

  // ----------------------------------------
  // fill / send sequencer
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    widx_d = widx_q;
    tid_d = tid_q;
    proto_d = proto_q;
    ready_d = ready_q;
    take = 1'b0;
    push = 1'b0;
    case (state_q)
      ST_FILL: begin
        take = ready_q && ITEM_VALID;
        if (take) begin
          if (cnt_q == ICNT_RST) begin
            tid_d = ITEM_SRC;
            proto_d = TRACE_PROTO;
          end
          if (cnt_q == LAST_ITEM) begin
            cnt_d = ICNT_RST;
            widx_d = WIDX_RST;
            state_d = ST_SEND;
            ready_d = 1'b0;
          end else begin
            cnt_d = cnt_q + 5'h01;
          end
        end
      end
      ST_SEND: begin
        push = buf_in_ready;
        if (push) begin
          if (widx_q == LAST_WORD) begin
            widx_d = WIDX_RST;
            state_d = ST_FILL;
            ready_d = 1'b1;
          end else begin
            widx_d = widx_q + 5'h01;
          end
        end
      end
      default: begin
        state_d = ST_FILL;
        cnt_d = ICNT_RST;
        widx_d = WIDX_RST;
        ready_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= ST_FILL;
      cnt_q <= ICNT_RST;
      widx_q <= WIDX_RST;
      tid_q <= SRC_RST;
      proto_q <= PROTO_DEFAULT;
      ready_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      widx_q <= widx_d;
      tid_q <= tid_d;
      proto_q <= proto_d;
      ready_q <= ready_d;
    end
  end

  assign ITEM_READY = ready_q;

  // ----------------------------------------
  // output buffer
  // ----------------------------------------
  assign buf_in = {(widx_q == LAST_WORD), tid_q, cur_word};

  trace_skid #(
    .W(BUF_W)
  ) u_skid (
    .clk(CLK),
    .rst_n(RST_N),
    .in_valid(push),
    .in_ready(buf_in_ready),
    .in_data(buf_in),
    .out_valid(M_AXIS_TVALID),
    .out_ready(M_AXIS_TREADY),
    .out_data(buf_out)
  );

  assign M_AXIS_TLAST = buf_out[BUF_W-1];
  assign M_AXIS_TID = buf_out[WORD_W +: SRC_W];
  assign M_AXIS_TDATA = buf_out[WORD_W-1:0];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [WIDX_W-1:0] beat_q, beat_d;
  logic [SRC_W-1:0] pkt_tid_q, pkt_tid_d;
  logic hs;

  assign hs = M_AXIS_TVALID && M_AXIS_TREADY;

  // beat index and packet TID as seen on the stream
  always_comb begin
    beat_d = beat_q;
    pkt_tid_d = pkt_tid_q;
    if (hs) begin
      beat_d = M_AXIS_TLAST ? WIDX_RST : beat_q + 5'h01;
      if (beat_q == WIDX_RST) begin
        pkt_tid_d = M_AXIS_TID;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      beat_q <= WIDX_RST;
      pkt_tid_q <= SRC_RST;
    end else begin
      beat_q <= beat_d;
      pkt_tid_q <= pkt_tid_d;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_last_on_eighteenth: assert property (hs |-> (M_AXIS_TLAST == (beat_q == LAST_WORD)))
    else $error("TLAST not on word 18");
  a_fill_to_send: assert property ((take && cnt_q == LAST_ITEM) |=> (state_q == ST_SEND && !ITEM_READY))
    else $error("packet did not close after item 32");
  a_tid_capture: assert property ((take && cnt_q == ICNT_RST) |=> tid_q == $past(ITEM_SRC))
    else $error("source index not captured");
  a_tid_per_packet: assert property ((M_AXIS_TVALID && beat_q != WIDX_RST) |-> M_AXIS_TID == pkt_tid_q)
    else $error("TID changed inside packet");

  // ----------------------------------------
  // placement checks and the stall-hold check
  // ----------------------------------------
  a_alt_layout: assert property (proto_q == PROTO_ALT |-> pkt_vec[5*ITEM_W +: ITEM_W] == item_q[5])
    else $error("alternate layout wrong");
  a_item5_place: assert property (proto_q == PROTO_DEFAULT |->
    {pkt_vec[139:138], pkt_vec[103:96], pkt_vec[95:88]} == item_q[5])
    else $error("item 5 misplaced");
  a_item7_place: assert property (proto_q == PROTO_DEFAULT |->
    {pkt_vec[143:142], pkt_vec[135:128], pkt_vec[127:120]} == item_q[7])
    else $error("item 7 misplaced");
  a_item12_place: assert property (proto_q == PROTO_DEFAULT |->
    {pkt_vec[281:280], pkt_vec[231:224], pkt_vec[223:216]} == item_q[12])
    else $error("item 12 misplaced");
  a_item14_place: assert property (proto_q == PROTO_DEFAULT |->
    {pkt_vec[285:284], pkt_vec[263:256], pkt_vec[255:248]} == item_q[14])
    else $error("item 14 misplaced");
  a_item21_place: assert property (proto_q == PROTO_DEFAULT |->
    {pkt_vec[427:426], pkt_vec[391:384], pkt_vec[383:376]} == item_q[21])
    else $error("item 21 misplaced");
  a_item30_place: assert property (proto_q == PROTO_DEFAULT |->
    {pkt_vec[573:572], pkt_vec[551:544], pkt_vec[543:536]} == item_q[30])
    else $error("item 30 misplaced");
  a_item0_place: assert property (proto_q == PROTO_DEFAULT |->
    {pkt_vec[65:64], pkt_vec[15:0]} == item_q[0])
    else $error("item 0 misplaced");
  a_item3_place: assert property (proto_q == PROTO_DEFAULT |->
    {pkt_vec[71:70], pkt_vec[63:48]} == item_q[3])
    else $error("item 3 misplaced");
  a_item8_place: assert property (proto_q == PROTO_DEFAULT |->
    {pkt_vec[209:208], pkt_vec[159:144]} == item_q[8])
    else $error("item 8 misplaced");
  a_item16_place: assert property (proto_q == PROTO_DEFAULT |->
    {pkt_vec[353:352], pkt_vec[303:288]} == item_q[16])
    else $error("item 16 misplaced");
  a_item19_place: assert property (proto_q == PROTO_DEFAULT |->
    {pkt_vec[359:358], pkt_vec[351:336]} == item_q[19])
    else $error("item 19 misplaced");
  a_item27_place: assert property (proto_q == PROTO_DEFAULT |->
    {pkt_vec[503:502], pkt_vec[495:480]} == item_q[27])
    else $error("item 27 misplaced");
  a_item31_place: assert property (proto_q == PROTO_DEFAULT |->
    {pkt_vec[575:574], pkt_vec[567:552]} == item_q[31])
    else $error("item 31 misplaced");
  a_stall_hold: assert property ((M_AXIS_TVALID && !M_AXIS_TREADY) |=>
    (M_AXIS_TVALID && $stable(M_AXIS_TDATA) && $stable(M_AXIS_TLAST) && $stable(M_AXIS_TID)))
    else $error("word changed under stall");

  // ----------------------------------------
  // sequencing checks
  // ----------------------------------------
  a_state_onehot: assert property ($onehot(state_q))
    else $error("sequencer state not one-hot");
  a_ready_fill: assert property (state_q == ST_FILL |-> ITEM_READY)
    else $error("item port closed while filling");
  a_no_take_send: assert property (state_q == ST_SEND |-> (!take && !ITEM_READY && cnt_q == ICNT_RST))
    else $error("item taken while packet is sent");
  a_item_write: assert property (take |=> item_q[$past(cnt_q)] == $past(ITEM_DATA))
    else $error("item not stored in its slot");
  a_proto_capture: assert property ((take && cnt_q == ICNT_RST) |=> proto_q == $past(TRACE_PROTO))
    else $error("layout select not captured");
  a_hold_in_packet: assert property ((take && cnt_q != ICNT_RST) |=>
    ($stable(proto_q) && $stable(tid_q)))
    else $error("packet source or layout changed mid-fill");
  a_first_beat_tid: assert property ((hs && beat_q == WIDX_RST) |-> M_AXIS_TID == tid_q)
    else $error("packet TID differs from its source");
  a_first_word: assert property ((take && cnt_q == LAST_ITEM) |-> ##[1:3] M_AXIS_TVALID)
    else $error("no stream word after packet closed");
  a_reopen_fill: assert property ((state_q == ST_SEND && push && widx_q == LAST_WORD) |=>
    (state_q == ST_FILL && ITEM_READY))
    else $error("fill did not reopen after word 18");

  // ----------------------------------------
  // scenario coverage
  // ----------------------------------------
  c_full_packet: cover property (hs && M_AXIS_TLAST);
  c_stall: cover property (M_AXIS_TVALID && !M_AXIS_TREADY [*3]);
  c_alt_packet: cover property (hs && M_AXIS_TLAST && proto_q == PROTO_ALT);
  c_default_packet: cover property (hs && M_AXIS_TLAST && proto_q == PROTO_DEFAULT);
  c_back_to_back: cover property (hs [*3]);

endmodule

/* hdl/trace_pkg.sv */
// shared constants and types for the trace packet packer
package trace_pkg;

  // ----------------------------------------
  // packet geometry
  // ----------------------------------------
  localparam int ITEM_W = 18;
  localparam int LOW_W = 16;
  localparam int HIGH_W = 2;
  localparam int WORD_W = 32;
  localparam int ITEMS_PER_PKT = 32;
  localparam int WORDS_PER_PKT = 18;
  localparam int PKT_BITS = WORD_W * WORDS_PER_PKT;
  localparam int GROUP_ITEMS = 4;
  localparam int GROUP_BITS = GROUP_ITEMS * ITEM_W;
  localparam int GROUP_HIGH_OFS = GROUP_ITEMS * LOW_W;
  localparam int NUM_GROUPS = ITEMS_PER_PKT / GROUP_ITEMS;

  // ----------------------------------------
  // counters and identifiers
  // ----------------------------------------
  localparam int SRC_W = 5;
  localparam int ICNT_W = 5;
  localparam int WIDX_W = 5;
  localparam logic [ICNT_W-1:0] LAST_ITEM = 5'h1F;
  localparam logic [WIDX_W-1:0] LAST_WORD = 5'h11;
  localparam logic [ICNT_W-1:0] ICNT_RST = 5'h00;
  localparam logic [WIDX_W-1:0] WIDX_RST = 5'h00;
  localparam logic [SRC_W-1:0] SRC_RST = 5'h00;

  // ----------------------------------------
  // layout selector
  // ----------------------------------------
  localparam logic PROTO_DEFAULT = 1'b0;
  localparam logic PROTO_ALT = 1'b1;

  typedef enum logic [1:0] {
    ST_FILL = 2'b01,
    ST_SEND = 2'b10
  } pack_state_e;

endpackage

/* hdl/trace_skid.sv */
// two-entry stream buffer with registered outputs
`timescale 1ns/10ps
module trace_skid #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  logic out_valid_q, out_valid_d;
  logic [W-1:0] out_data_q, out_data_d;
  logic skid_valid_q, skid_valid_d;
  logic [W-1:0] skid_data_q, skid_data_d;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    out_valid_d = out_valid_q;
    out_data_d = out_data_q;
    skid_valid_d = skid_valid_q;
    skid_data_d = skid_data_q;
    if (out_ready || !out_valid_q) begin
      if (skid_valid_q) begin
        out_valid_d = 1'b1;
        out_data_d = skid_data_q;
        skid_valid_d = 1'b0;
      end else begin
        out_valid_d = in_valid;
        if (in_valid) begin
          out_data_d = in_data;
        end
      end
    end else if (in_valid && !skid_valid_q) begin
      // receiver stalled: park the word instead of dropping it
      skid_valid_d = 1'b1;
      skid_data_d = in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid_q <= 1'b0;
      out_data_q <= '0;
      skid_valid_q <= 1'b0;
      skid_data_q <= '0;
    end else begin
      out_valid_q <= out_valid_d;
      out_data_q <= out_data_d;
      skid_valid_q <= skid_valid_d;
      skid_data_q <= skid_data_d;
    end
  end

  assign in_ready = !skid_valid_q;
  assign out_valid = out_valid_q;
  assign out_data = out_data_q;

endmodule

/* tb/trace_packer_tb.sv */
// self-checking bench for the trace packet packer
`timescale 1ns/10ps
module trace_packer_tb
  import trace_pkg::*;
;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic TRACE_PROTO = 1'b0;
  logic ITEM_VALID = 1'b0;
  logic ITEM_READY;
  logic [ITEM_W-1:0] ITEM_DATA = 18'h0_0000;
  logic [SRC_W-1:0] ITEM_SRC = 5'h00;
  logic M_AXIS_TVALID;
  logic M_AXIS_TREADY;
  logic [WORD_W-1:0] M_AXIS_TDATA;
  logic M_AXIS_TLAST;
  logic [SRC_W-1:0] M_AXIS_TID;
  logic slow = 1'b0;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;

  always #10 CLK = ~CLK;

  trace_packer trace_packer_inst (.CLK(CLK), .RST_N(RST_N), .TRACE_PROTO(TRACE_PROTO),
    .ITEM_VALID(ITEM_VALID), .ITEM_READY(ITEM_READY), .ITEM_DATA(ITEM_DATA), .ITEM_SRC(ITEM_SRC),
    .M_AXIS_TVALID(M_AXIS_TVALID), .M_AXIS_TREADY(M_AXIS_TREADY), .M_AXIS_TDATA(M_AXIS_TDATA),
    .M_AXIS_TLAST(M_AXIS_TLAST), .M_AXIS_TID(M_AXIS_TID));

  trace_sink trace_sink_inst (.clk(CLK), .slow(slow), .tvalid(M_AXIS_TVALID), .tready(M_AXIS_TREADY),
    .tdata(M_AXIS_TDATA), .tlast(M_AXIS_TLAST), .tid(M_AXIS_TID));

  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (exp !== got) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // expected packet image from the placement scheme
  function automatic logic [PKT_BITS-1:0] build(input logic proto, input logic [31:0][17:0] it);
    logic [PKT_BITS-1:0] v;
    v = '0;
    for (int i = 0; i < 32; i++) begin
      if (proto) begin
        v[18*i +: 18] = it[i];
      end else begin
        v[72*(i/4) + 16*(i%4) +: 16] = it[i][15:0];
        v[72*(i/4) + 64 + 2*(i%4) +: 2] = it[i][17:16];
      end
    end
    return v;
  endfunction

  // spot checks of received words against the placement table
  task automatic check_table(input int s, input logic [31:0][17:0] it);
    logic [31:0] w [18];
    for (int j = 0; j < 18; j++) begin
      w[j] = trace_sink_inst.words[s+j];
    end
    chk("item 5", {14'h0, it[5]}, {14'h0, w[4][11:10], w[3][7:0], w[2][31:24]});
    chk("item 7", {14'h0, it[7]}, {14'h0, w[4][15:14], w[4][7:0], w[3][31:24]});
    chk("item 12", {14'h0, it[12]}, {14'h0, w[8][25:24], w[7][7:0], w[6][31:24]});
    chk("item 14", {14'h0, it[14]}, {14'h0, w[8][29:28], w[8][7:0], w[7][31:24]});
    chk("item 21", {14'h0, it[21]}, {14'h0, w[13][11:10], w[12][7:0], w[11][31:24]});
    chk("item 30", {14'h0, it[30]}, {14'h0, w[17][29:28], w[17][7:0], w[16][31:24]});
    chk("item 0", {14'h0, it[0]}, {14'h0, w[2][1:0], w[0][15:0]});
  endtask

  task automatic send_and_check(input logic proto, input logic [4:0] src, input logic [17:0] base,
    input logic stall);
    logic [31:0][17:0] it;
    logic [PKT_BITS-1:0] exp;
    int start;
    int k;
    start = trace_sink_inst.n;
    slow = stall;
    for (int i = 0; i < 32; i++) begin
      it[i] = 18'(i * 32'h9A6B) ^ base;
    end
    for (int i = 0; i < 32; i++) begin
      @(negedge CLK);
      ITEM_VALID = 1'b1;
      ITEM_DATA = it[i];
      ITEM_SRC = (i == 0) ? src : ~src;
      TRACE_PROTO = (i == 0) ? proto : ~proto;
      k = 0;
      while (ITEM_READY !== 1'b1 && k < 200) begin
        @(negedge CLK);
        k++;
      end
    end
    @(negedge CLK);
    ITEM_VALID = 1'b0;
    k = 0;
    while (trace_sink_inst.n < start + 18 && k < 400) begin
      @(negedge CLK);
      k++;
    end
    exp = build(proto, it);
    for (int w = 0; w < 18; w++) begin
      chk("word", exp[32*w +: 32], trace_sink_inst.words[start+w]);
      chk("last", {31'h0, w == 17}, {31'h0, trace_sink_inst.lasts[start+w]});
      chk("tid", {27'h0, src}, {27'h0, trace_sink_inst.tids[start+w]});
    end
    if (proto == PROTO_DEFAULT) begin
      check_table(start, it);
    end
    chk("count", 32'(start + 18), 32'(trace_sink_inst.n));
  endtask

  task automatic test_reset();
    chk("item ready", 32'h1, {31'h0, ITEM_READY});
    chk("valid", 32'h0, {31'h0, M_AXIS_TVALID});
    $display("test reset done");
  endtask

  task automatic test_default();
    send_and_check(PROTO_DEFAULT, 5'h05, 18'h3_A5C1, 1'b0);
    $display("test default done");
  endtask

  task automatic test_alt_stall();
    send_and_check(PROTO_ALT, 5'h1F, 18'h1_5E3B, 1'b1);
    $display("test alternate stall done");
  endtask

  task automatic test_default_stall();
    send_and_check(PROTO_DEFAULT, 5'h00, 18'h2_F0F0, 1'b1);
    $display("test default stall done");
  endtask

  initial begin
    repeat (12) @(posedge CLK);
    @(negedge CLK);
    RST_N = 1'b1;
    @(negedge CLK);
    test_reset();
    test_default();
    test_alt_stall();
    test_default_stall();
    print_verdict();
  end
endmodule

/* tb/trace_sink.sv */
// stream slave model that takes words and records them
`timescale 1ns/10ps
module trace_sink
  import trace_pkg::*;
(
  input wire logic clk,
  input wire logic slow,
  input wire logic tvalid,
  output logic tready,
  input wire logic [WORD_W-1:0] tdata,
  input wire logic tlast,
  input wire logic [SRC_W-1:0] tid
);
  logic [WORD_W-1:0] words [0:127];
  logic lasts [0:127];
  logic [SRC_W-1:0] tids [0:127];
  int n = 0;
  int tick = 0;

  // stall pattern: ready one cycle in three when slow
  always @(negedge clk) begin
    tick <= tick + 1;
    tready <= !slow || (tick % 3 == 0);
  end

  // a word moves only with valid and ready high
  always @(posedge clk) begin
    if (tvalid === 1'b1 && tready === 1'b1) begin
      words[n] <= tdata;
      lasts[n] <= tlast;
      tids[n] <= tid;
      n <= n + 1;
    end
  end
endmodule
